// [fpr_stage.sv]
/*
  Dead-time PWM stage with 16-cycle fractional frequency modulation and two
  retrigger or fault input modules, one per sub-cycle.
  Assumes all control inputs are synchronous to ref_clk and held steady by the
  user while a cycle runs; there is no shadow update of the time values.
*/
// Contract
// - Enhanced mode groups cycles into frames of 16 and mixes two base periods.
// - Exactly d cycles per frame get the longer period, spread evenly.
// - Lengthened slots are added in order 0,8,4,12,2,10,6,14,1,9,5,13,3,11,7.
// - A lengthened cycle adds one count during the first-output sub-cycle.
// - Normal cycle lasts sum of both on-times and both dead-times.
// - Two input modules, A and B, each set as retrigger or fault.
// - Centre-aligned mode ignores all retrigger events.
// - Two and four ramp: retrigger ends own sub-cycle, starts the other.
// - One ramp: retrigger on either input restarts the ramp from zero.
// - Input A can end out_a early; none, level or edge, chosen polarity.
// - Input B can end out_b early; none, level or edge, chosen polarity.
// - Each input takes comparator output or external pin as selected.
// - Optional filter needs four stable clocks before retrigger or gating uses the input.
// - Async kill bit lets any active input with a non-zero mode drop its own output without clock.
// - Polarity setting picks the active edge or the active level.
// - Polarity set means rising or high; clear means falling or low.
// - Fractional divider d is bits 15 to 12 of reset_compare_b.
// - Four-bit input mode field; code zero means the input does nothing.
// - Two and four ramp: input A only in A sub-cycle, B only in B.
`timescale 1ns/1ps
module fpr_stage import fpr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Run control
  input wire logic run_en,
  input wire logic [1:0] ramp_mode,
  input wire logic enhanced_en,
  // Time values in stage clocks
  input wire logic [TIME_W-1:0] on_time_a,
  input wire logic [TIME_W-1:0] on_time_b,
  input wire logic [TIME_W-1:0] dead_time_a,
  input wire logic [TIME_W-1:0] dead_time_b,
  input wire logic [CMP_W-1:0] reset_compare_b,
  // Input sources, index 0 is input A and index 1 is input B
  input wire logic [1:0] comparator_in,
  input wire logic [1:0] fault_pin,
  // Input configuration, same indexing
  input wire logic [1:0] source_sel,
  input wire logic [1:0] filter_en,
  input wire logic [1:0] input_polarity,
  input wire logic [1:0] async_output_kill,
  input wire logic [MODE_W-1:0] input_mode_field_a,
  input wire logic [MODE_W-1:0] input_mode_field_b,
  // Power switch outputs
  output logic out_a,
  output logic out_b,
  // Status
  output logic cycle_done,
  output logic [SLOT_W-1:0] frame_slot,
  output logic lengthened,
  output logic [1:0] input_active
);

  typedef struct packed {
    fpr_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic out_a;
    logic out_b;
    logic cycle_done;
    logic [SLOT_W-1:0] slot;
    logic lengthened;
    logic [1:0] in_act;
  } fpr_stage_state_t;

  fpr_stage_state_t st;
  fpr_stage_state_t next_st;

  logic [MODE_W-1:0] mode [2];
  logic [1:0] in_active;
  logic [1:0] in_edge;
  logic [1:0] in_kill;
  logic [1:0] kill_en;
  logic [1:0] window;
  logic [1:0] retrig;
  logic [1:0] gate;
  logic frame_restart;
  logic frame_cycle_end;
  logic [SLOT_W-1:0] slot_now;
  logic lengthen_now;
  logic [CNT_W-1:0] phase_len;
  logic phase_last;
  logic sub_a;
  logic sub_b;

  assign mode[0] = input_mode_field_a;
  assign mode[1] = input_mode_field_b;

  // Input modules, one per sub-cycle
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_input
      // Async kill only for an input that is given a mode at all
      assign kill_en[gi] = async_output_kill[gi] && (mode[gi] != IMODE_NONE);

      fpr_input u_input (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .comparator_in(comparator_in[gi]),
        .fault_pin(fault_pin[gi]),
        .source_sel(source_sel[gi]),
        .filter_en(filter_en[gi]),
        .input_polarity(input_polarity[gi]),
        .kill_en(kill_en[gi]),
        .active(in_active[gi]),
        .active_edge(in_edge[gi]),
        .kill_now(in_kill[gi])
      );
    end
  endgenerate

  fpr_frame u_frame (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .restart(frame_restart),
    .cycle_end(frame_cycle_end),
    .enhanced_en(enhanced_en),
    .frac_d(reset_compare_b[FRAC_MSB:FRAC_LSB]),
    .slot(slot_now),
    .lengthen(lengthen_now)
  );

  assign sub_a = (st.phase == PH_DEAD_A) || (st.phase == PH_ON_A);
  assign sub_b = (st.phase == PH_DEAD_B) || (st.phase == PH_ON_B);

  // One ramp honours inputs over the whole ramp
  assign window[0] = (ramp_mode == RAMP_ONE) || sub_a;
  assign window[1] = (ramp_mode == RAMP_ONE) || sub_b;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_event
      assign retrig[gi] = in_edge[gi] && fpr_is_retrig(mode[gi]) && window[gi]
                          && (ramp_mode != RAMP_CENTRE);
      assign gate[gi] = in_active[gi] && fpr_is_gating(mode[gi]);
    end
  endgenerate

  // Length of the running phase; the extra count goes into on_time_a
  always_comb begin
    case (st.phase)
      PH_DEAD_A: phase_len = {1'b0, dead_time_a};
      PH_ON_A: phase_len = {1'b0, on_time_a} + {12'h000, lengthen_now};
      PH_DEAD_B: phase_len = {1'b0, dead_time_b};
      PH_ON_B: phase_len = {1'b0, on_time_b};
      default: phase_len = CNT_RESET;
    endcase
  end

  // A zero-length phase still takes one clock
  assign phase_last = (phase_len == CNT_RESET) || (st.cnt == phase_len - 13'h0001);

  always_comb begin
    next_st = st;
    next_st.cycle_done = 1'b0;
    frame_restart = 1'b0;
    if (!run_en) begin
      next_st.phase = PH_IDLE;
      next_st.cnt = CNT_RESET;
      frame_restart = 1'b1;
    end else begin
      if (st.phase == PH_IDLE) begin
        next_st.phase = PH_DEAD_A;
        next_st.cnt = CNT_RESET;
      end else if (phase_last) begin
        next_st.cnt = CNT_RESET;
        case (st.phase)
          PH_DEAD_A: next_st.phase = PH_ON_A;
          PH_ON_A: next_st.phase = PH_DEAD_B;
          PH_DEAD_B: next_st.phase = PH_ON_B;
          PH_ON_B: begin
            next_st.phase = PH_DEAD_A;
            next_st.cycle_done = 1'b1;
          end
          default: next_st.phase = PH_IDLE;
        endcase
      end else begin
        next_st.cnt = st.cnt + 13'h0001;
      end
      // Retrigger overrides the normal timing step
      if (st.phase != PH_IDLE) begin
        if (ramp_mode == RAMP_ONE) begin
          if (retrig != 2'b00) begin
            next_st.phase = PH_DEAD_A;
            next_st.cnt = CNT_RESET;
            next_st.cycle_done = 1'b0;
          end
        end else if (retrig[0]) begin
          next_st.phase = PH_DEAD_B;
          next_st.cnt = CNT_RESET;
          next_st.cycle_done = 1'b0;
        end else if (retrig[1]) begin
          next_st.phase = PH_DEAD_A;
          next_st.cnt = CNT_RESET;
          next_st.cycle_done = 1'b1;
        end
      end
    end
    // Outputs follow the phase they enter, held off by a gating input
    next_st.out_a = (next_st.phase == PH_ON_A) && !gate[0];
    next_st.out_b = (next_st.phase == PH_ON_B) && !gate[1];
    next_st.slot = slot_now;
    next_st.lengthened = lengthen_now;
    next_st.in_act = in_active;
  end

  assign frame_cycle_end = next_st.cycle_done;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The unclocked kill must not wait for an edge, so it gates the flop here
  assign out_a = st.out_a && !in_kill[0];
  assign out_b = st.out_b && !in_kill[1];
  assign cycle_done = st.cycle_done;
  assign frame_slot = st.slot;
  assign lengthened = st.lengthened;
  assign input_active = st.in_act;

endmodule : fpr_stage

// [fpr_pkg.sv]
/*
  Shared constants, state types and mode decoders for the fractional PWM stage.
  Assumes every user of it runs on ref_clk with the active-low reset rst_b.
*/
package fpr_pkg;

  // Widths of the time fields, the phase counter and the frame slot
  localparam int TIME_W = 12;
  localparam int CNT_W = 13;
  localparam int SLOT_W = 4;
  localparam int MODE_W = 4;
  localparam int CMP_W = 16;

  // Fractional divider sits in the top nibble of reset_compare_b
  localparam int FRAC_LSB = 12;
  localparam int FRAC_MSB = 15;

  // Frame and filter sizes
  localparam int FRAME_LEN = 16;
  localparam int FILTER_LEN = 4;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hF;

  // Ramp mode codes on ramp_mode
  localparam logic [1:0] RAMP_ONE = 2'h0;
  localparam logic [1:0] RAMP_TWO = 2'h1;
  localparam logic [1:0] RAMP_FOUR = 2'h2;
  localparam logic [1:0] RAMP_CENTRE = 2'h3;

  // Input mode codes on input_mode_field; other codes neither retrigger nor gate but still enable async kill
  localparam logic [MODE_W-1:0] IMODE_NONE = 4'h0;
  localparam logic [MODE_W-1:0] IMODE_LEVEL_RETRIG = 4'h1;
  localparam logic [MODE_W-1:0] IMODE_LEVEL_FAULT = 4'h4;
  localparam logic [MODE_W-1:0] IMODE_EDGE_RETRIG = 4'h8;

  // Values after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 4'h0;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEAD_A,
    PH_ON_A,
    PH_DEAD_B,
    PH_ON_B
  } fpr_phase_t;

  // Input codes whose active edge retriggers the waveform
  function automatic logic fpr_is_retrig(input logic [MODE_W-1:0] mode);
    fpr_is_retrig = (mode == IMODE_LEVEL_RETRIG) || (mode == IMODE_EDGE_RETRIG);
  endfunction : fpr_is_retrig

  // Input codes whose active level holds the owning output off
  function automatic logic fpr_is_gating(input logic [MODE_W-1:0] mode);
    fpr_is_gating = (mode == IMODE_LEVEL_RETRIG) || (mode == IMODE_LEVEL_FAULT);
  endfunction : fpr_is_gating

  // Bit reversal gives the rank of a slot in the spreading order
  function automatic logic [SLOT_W-1:0] fpr_bitrev(input logic [SLOT_W-1:0] v);
    fpr_bitrev = {v[0], v[1], v[2], v[3]};
  endfunction : fpr_bitrev

endpackage : fpr_pkg

// [fpr_input.sv]
/*
  One input module: source select, polarity, optional 4-sample filter and edge detect.
  Assumes comparator and pin inputs are already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module fpr_input import fpr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Sources
  input wire logic comparator_in,
  input wire logic fault_pin,
  // Configuration
  input wire logic source_sel,
  input wire logic filter_en,
  input wire logic input_polarity,
  input wire logic kill_en,
  // Results
  output logic active,
  output logic active_edge,
  output logic kill_now
);

  typedef struct packed {
    logic [FILTER_LEN-1:0] hist;
    logic filt;
    logic edge_p;
  } fpr_in_state_t;

  fpr_in_state_t st;
  fpr_in_state_t next_st;
  logic raw;
  logic polar;

  // Pin when source_sel is set, comparator otherwise
  assign raw = source_sel ? fault_pin : comparator_in;
  // Set polarity means high or rising is active
  assign polar = input_polarity ? raw : ~raw;
  // Unclocked path so a stopped clock cannot hold the outputs on
  assign kill_now = kill_en & polar;

  always_comb begin
    next_st = st;
    next_st.hist = {st.hist[FILTER_LEN-2:0], polar};
    if (!filter_en) begin
      next_st.filt = polar;
    end else if (next_st.hist == '1) begin
      next_st.filt = 1'b1;
    end else if (next_st.hist == '0) begin
      next_st.filt = 1'b0;
    end
    next_st.edge_p = next_st.filt & ~st.filt;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.filt;
  assign active_edge = st.edge_p;

endmodule : fpr_input

// [fpr_frame.sv]
/*
  Frame slot counter and lengthen decision for the enhanced resolution mode.
  Assumes cycle_end is a one-cycle pulse at the wrap of each complete waveform.
*/
`timescale 1ns/1ps
module fpr_frame import fpr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic restart,
  input wire logic cycle_end,
  input wire logic enhanced_en,
  input wire logic [SLOT_W-1:0] frac_d,
  // Results
  output logic [SLOT_W-1:0] slot,
  output logic lengthen
);

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic lengthen;
  } fpr_frame_state_t;

  fpr_frame_state_t st;
  fpr_frame_state_t next_st;

  always_comb begin
    next_st = st;
    if (restart) begin
      next_st.slot = SLOT_RESET;
    end else if (cycle_end) begin
      next_st.slot = st.slot + 4'h1;
    end
    // Slot rank below d lengthens; d of zero lengthens nothing
    next_st.lengthen = enhanced_en && (fpr_bitrev(next_st.slot) < frac_d);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slot = st.slot;
  assign lengthen = st.lengthen;

endmodule : fpr_frame

// [fpr_checker.sv]
/* Port-level assertions for fpr_stage.
   Assumes ref_clk with async active-low rst_b; bound below to every fpr_stage. */
`timescale 1ns/1ps
module fpr_checker import fpr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched inputs
  input wire logic run_en,
  input wire logic enhanced_en,
  input wire logic [CMP_W-1:0] reset_compare_b,
  input wire logic [1:0] comparator_in,
  input wire logic [1:0] fault_pin,
  input wire logic [1:0] source_sel,
  input wire logic [1:0] input_polarity,
  input wire logic [1:0] async_output_kill,
  input wire logic [MODE_W-1:0] input_mode_field_b,
  // Watched outputs
  input wire logic out_a,
  input wire logic out_b,
  input wire logic cycle_done,
  input wire logic [SLOT_W-1:0] frame_slot,
  input wire logic lengthened
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic raw_b;
  logic [3:0] rev;
  logic [4:0] run_cnt;
  assign raw_b = (source_sel[1] ? fault_pin[1] : comparator_in[1]) == input_polarity[1];
  assign rev = {frame_slot[0], frame_slot[1], frame_slot[2], frame_slot[3]};
  // Stale lengthen flags from an earlier setting may linger in idle, so wait out 31 clocks of run
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) run_cnt <= 5'h00;
    else if (!run_en) run_cnt <= 5'h00;
    else if (run_cnt != 5'h1F) run_cnt <= run_cnt + 5'h01;
  end
  a_done_single: assert property (cycle_done |=> !cycle_done [*2])
    else $error("cycle_done pulses too close");
  a_slot_step: assert property (run_en && $past(run_en) && $past(run_en, 2) &&
    frame_slot != $past(frame_slot) |-> frame_slot == $past(frame_slot) + 4'h1)
    else $error("frame slot skipped");
  a_no_overlap: assert property (!(out_a && out_b))
    else $error("both outputs active");
  a_gap_before_b: assert property ($rose(out_b) |-> !$past(out_a))
    else $error("no dead time before out_b");
  a_kill_async: assert property (async_output_kill[1] && raw_b &&
    input_mode_field_b != IMODE_NONE |-> !out_b)
    else $error("out_b not killed");
  a_idle_quiet: assert property (!run_en && !$past(run_en) |-> !out_a && !out_b)
    else $error("output active while stopped");
  a_len_off: assert property (run_cnt == 5'h1F && (!enhanced_en ||
    reset_compare_b[FRAC_MSB:FRAC_LSB] == 4'h0) |-> !lengthened)
    else $error("cycle lengthened without divider");
  a_len_pattern: assert property (run_cnt == 5'h1F && lengthened && $stable(lengthened) &&
    $stable(frame_slot) |-> rev < reset_compare_b[FRAC_MSB:FRAC_LSB])
    else $error("lengthened slot outside pattern");
  c_len: cover property (lengthened);
  c_done: cover property (cycle_done);
  c_kill: cover property (async_output_kill[1] && raw_b && input_mode_field_b != IMODE_NONE);
endmodule : fpr_checker

bind fpr_stage fpr_checker chk_u (.ref_clk, .rst_b, .run_en, .enhanced_en, .reset_compare_b,
  .comparator_in, .fault_pin, .source_sel, .input_polarity, .async_output_kill,
  .input_mode_field_b, .out_a, .out_b, .cycle_done, .frame_slot, .lengthened);

// [fpr_src.sv]
/* Behavioural comparator or fault-pin source, two lines.
   Assumes the bench raises fire for one ref_clk cycle to launch a pulse. */
`timescale 1ns/1ps
module fpr_src (
  // Clock
  input wire logic ref_clk,
  // Bench control
  input wire logic [1:0] fire,
  input wire logic [1:0] idle_lvl,
  input wire logic [3:0] width,
  // Lines into the stage
  output logic [1:0] line
);
  logic [3:0] cnt [2] = '{4'h0, 4'h0};
  always @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (fire[i]) cnt[i] <= width;
      else if (cnt[i] != 4'h0) cnt[i] <= cnt[i] - 4'h1;
    end
  end
  // Idle level tracks polarity, so only a launched pulse is ever an active event
  assign line = {cnt[1] != 4'h0, cnt[0] != 4'h0} ^ idle_lvl;
endmodule : fpr_src

// [tb_fractional_pwm_retrigger.sv]
/* Self-checking bench for fpr_stage: frame pattern, retrigger, async kill, filter.
   Assumes fpr_checker is bound from its own file and fpr_src models the sources. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_fractional_pwm_retrigger import fpr_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic run_en = 1'b0;
  logic enhanced_en = 1'b0;
  logic [1:0] ramp_mode = RAMP_TWO;
  logic [11:0] on_time_a = 12'h003, on_time_b = 12'h003, dead_time_a = 12'h002;
  logic [11:0] dead_time_b = 12'h002;
  logic [15:0] reset_compare_b = 16'h0000;
  logic [1:0] source_sel = 2'h0, filter_en = 2'h0, input_polarity = 2'h3;
  logic [1:0] async_output_kill = 2'h0, fire_p = 2'h0, fire_c = 2'h0;
  logic [3:0] input_mode_field_a = 4'h0, input_mode_field_b = 4'h0, wid = 4'h1;
  logic out_a, out_b, cycle_done, lengthened;
  logic [3:0] frame_slot;
  logic [1:0] input_active, pin, cmp;
  int n_fail = 0;
  int checks = 0;

  fpr_src pin_u (.ref_clk, .fire(fire_p), .idle_lvl(~input_polarity), .width(wid), .line(pin));
  fpr_src cmp_u (.ref_clk, .fire(fire_c), .idle_lvl(~input_polarity), .width(wid), .line(cmp));
  fpr_stage dut_u (.ref_clk, .rst_b, .run_en, .ramp_mode, .enhanced_en, .on_time_a,
    .on_time_b, .dead_time_a, .dead_time_b, .reset_compare_b, .comparator_in(cmp),
    .fault_pin(pin), .source_sel, .filter_en, .input_polarity, .async_output_kill,
    .input_mode_field_a, .input_mode_field_b, .out_a, .out_b, .cycle_done, .frame_slot,
    .lengthened, .input_active);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Stopping first restarts the frame at slot 0; low bits of the compare value are junk
  task automatic start(logic [1:0] rm, logic [11:0] ot, logic en, logic [3:0] d);
    run_en = 1'b0;
    tick;
    tick;
    ramp_mode = rm;
    on_time_a = ot;
    enhanced_en = en;
    reset_compare_b = {d, 12'hABC};
    run_en = 1'b1;
  endtask : start

  task automatic measure(output int per, output int ha, output logic [3:0] s);
    int n;
    n = 0;
    while (cycle_done !== 1'b1 && n < 100) begin tick; n++; end
    per = 0;
    ha = 0;
    s = 4'h0;
    do begin
      tick;
      per++;
      if (out_a === 1'b1) begin ha++; s = frame_slot; end
    end while (cycle_done !== 1'b1 && per < 100);
  endtask : measure

  task automatic t_frame;
    int per, ha, nl, x;
    logic [3:0] s, ps, rv;
    logic [3:0] dl [4] = '{4'h0, 4'h5, 4'hF, 4'h5};
    logic el [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 4; k++) begin
      start(RAMP_FOUR, 12'h003, el[k], dl[k]);
      measure(per, ha, ps);
      nl = 0;
      for (int i = 0; i < 16; i++) begin
        measure(per, ha, s);
        rv = {s[0], s[1], s[2], s[3]};
        x = (el[k] && rv < dl[k]) ? 1 : 0;
        `CHK(per, 10 + x)
        `CHK(ha, 3 + x)
        `CHK(s, ps + 4'h1)
        `CHK(lengthened, 1'(x))
        ps = s;
        nl += per - 10;
      end
      `CHK(nl, el[k] ? int'(dl[k]) : 0)
    end
  endtask : t_frame

  task automatic t_retrig;
    logic [1:0] rm [4] = '{RAMP_TWO, RAMP_FOUR, RAMP_CENTRE, RAMP_ONE};
    int eh [4] = '{3, 3, 6, 3};
    logic eb [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int n;
    for (int k = 0; k < 4; k++) begin
      source_sel = {1'b0, k[0]};
      input_polarity = {1'b1, k[1]};
      input_mode_field_a = IMODE_EDGE_RETRIG;
      wid = 4'h1;
      start(rm[k], 12'h006, 1'b0, 4'h0);
      n = 0;
      while (out_a !== 1'b1 && n < 50) begin tick; n++; end
      fire_p = {1'b0, k[0]};
      fire_c = {1'b0, !k[0]};
      tick;
      fire_p = 2'h0;
      fire_c = 2'h0;
      n = 1;
      while (out_a === 1'b1 && n < 20) begin tick; n++; end
      `CHK(n, eh[k])
      tick;
      tick;
      `CHK(out_b, eb[k])
    end
  endtask : t_retrig

  task automatic t_kill;
    logic [3:0] md [2] = '{IMODE_NONE, IMODE_LEVEL_FAULT};
    int n;
    for (int k = 0; k < 2; k++) begin
      source_sel = 2'h2;
      input_polarity = 2'h2;
      async_output_kill = 2'h2;
      input_mode_field_a = IMODE_NONE;
      input_mode_field_b = md[k];
      wid = 4'h3;
      start(RAMP_TWO, 12'h003, 1'b0, 4'h0);
      n = 0;
      while (out_b !== 1'b1 && n < 50) begin tick; n++; end
      fire_p = 2'h2;
      tick;
      fire_p = 2'h0;
      // Pin rose at this edge; the clocked gate has not seen it yet, only the kill path
      `CHK(out_b, !k[0])
    end
  endtask : t_kill

  task automatic t_filter;
    logic fl [3] = '{1'b0, 1'b1, 1'b1};
    logic [3:0] wl [3] = '{4'h2, 4'h2, 4'h6};
    logic ex [3] = '{1'b1, 1'b0, 1'b1};
    logic seen;
    for (int k = 0; k < 3; k++) begin
      filter_en = {1'b0, fl[k]};
      source_sel = 2'h1;
      input_polarity = 2'h1;
      async_output_kill = 2'h0;
      wid = wl[k];
      tick;
      fire_p = 2'h1;
      tick;
      fire_p = 2'h0;
      seen = 1'b0;
      repeat (12) begin
        tick;
        if (input_active[0] === 1'b1) seen = 1'b1;
      end
      `CHK(seen, ex[k])
    end
  endtask : t_filter

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    tick;
    t_frame;
    t_retrig;
    t_kill;
    t_filter;
    end_of_test;
  end

  initial begin
    #500000;
    n_fail++;
    end_of_test;
  end
endmodule : tb_fractional_pwm_retrigger
